// [msru_pkg.sv]
// Package for the memory sync and reservation unit: opcodes, layout, condition codes
package msru_pkg;
    // Operation class presented by dispatch
    typedef enum logic [2:0] {
        MSRU_OP_NONE,
        MSRU_OP_LOAD_RSV,
        MSRU_OP_STORE_COND,
        MSRU_OP_SYNC,
        MSRU_OP_EIEIO,
        MSRU_OP_ISYNC,
        MSRU_OP_MEM_CI
    } msru_op_type;

    // Bus operation codes driven toward the system bus
    typedef enum logic [1:0] {
        MSRU_BUS_IDLE,
        MSRU_BUS_SYNC,
        MSRU_BUS_EIEIO
    } msru_bus_type;

    localparam int unsigned MSRU_ADDR_W     = 64;
    localparam int unsigned MSRU_BLOCK_BITS = 6;   // 64-byte block
    localparam int unsigned MSRU_WORD_BITS  = 2;   // Word alignment
    localparam int unsigned MSRU_DWORD_BITS = 3;   // Doubleword alignment
    localparam int unsigned MSRU_CR_W       = 4;
    localparam logic [3:0]  MSRU_CR_UNDEF   = 4'h0; // Chosen undefined value
    localparam logic [3:0]  MSRU_CR_EQ      = 4'h2; // Success bit position
    localparam logic [3:0]  MSRU_CR_FAIL    = 4'h0;
endpackage

// [msru_rsv.sv]
// Reservation holder with 64-byte block granularity
`timescale 1ns/10ps
module msru_rsv
    import msru_pkg::*;
#(
    parameter int unsigned ADDR_W = MSRU_ADDR_W
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              set_rsv,
    input  wire logic              clr_rsv,
    input  wire logic [ADDR_W-1:0] addr,
    output logic                   hit
);
    logic                                 valid;
    logic [ADDR_W-MSRU_BLOCK_BITS-1:0]    block;

    // Set wins over a clear in the same cycle so a fresh reservation survives
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            valid <= 1'b0;
            block <= '0;
        end else if (set_rsv) begin
            valid <= 1'b1;
            block <= addr[ADDR_W-1:MSRU_BLOCK_BITS];
        end else if (clr_rsv) begin
            valid <= 1'b0;
        end
    end

    // Only block bits compare, so any byte in the block matches
    assign hit = valid && (block == addr[ADDR_W-1:MSRU_BLOCK_BITS]);
endmodule

// [msru_core.sv]
// Memory sync and reservation unit: barriers, reservations, condition results
// Functional notes
// - Unaligned reservation-op address raises an alignment exception.
// - Reservations match anywhere within one 64-byte block.
// - Sync dispatches with older ops; younger dispatch blocked until done.
// - Buffered prefetched instructions are kept after sync completes.
// - Sync goes to load/store unit and a bus sync is issued.
// - Record bit on sync or load-reserve leaves condition field undefined.
// - Conditional store with record bit clear: condition field undefined.
// - Eieio waits for older I/O accesses and holds younger ones.
// - Eieio broadcasts an address-only ordering operation on the bus.
// - Isync waits for older ops, purges, refetches next doubleword.
`timescale 1ns/10ps
module msru_core
    import msru_pkg::*;
#(
    parameter int unsigned ADDR_W = MSRU_ADDR_W
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              op_valid,
    input  wire msru_op_type       op_kind,
    input  wire logic              op_record_bit,
    input  wire logic [ADDR_W-1:0] op_addr,
    input  wire logic [ADDR_W-1:0] op_next_pc,
    input  wire logic              older_done,
    input  wire logic              older_io_done,
    input  wire logic              bus_ack,
    input  wire logic              snoop_kill,
    output logic                   dispatch_stall,
    output logic                   io_hold,
    output logic                   align_exc,
    output logic                   load_store_unit_issue,
    output msru_op_type            load_store_unit_kind,
    output msru_bus_type           bus_op,
    output logic                   bus_req,
    output logic                   cond_we,
    output logic [MSRU_CR_W-1:0]   condition_field_zero,
    output logic                   store_we,
    output logic                   purge_prefetch,
    output logic                   fetch_req,
    output logic [ADDR_W-1:0]      fetch_addr
);
    typedef enum logic [2:0] {
        MSRU_ST_IDLE,
        MSRU_ST_SYNC_WAIT,
        MSRU_ST_SYNC_BUS,
        MSRU_ST_EIEIO_WAIT,
        MSRU_ST_EIEIO_BUS,
        MSRU_ST_ISYNC_WAIT
    } msru_state_type;

    msru_state_type    state;
    msru_state_type    next_state;
    logic [ADDR_W-1:0] isync_pc;
    logic              misaligned;
    logic              is_rsv_op;
    logic              rsv_hit;
    logic              take;

    // Word alignment check on the low address bits
    assign misaligned = |op_addr[MSRU_WORD_BITS-1:0];
    assign is_rsv_op  = op_kind == MSRU_OP_LOAD_RSV ||
                        op_kind == MSRU_OP_STORE_COND;
    // New ops are only accepted while idle; a held barrier refuses them
    assign take = op_valid && state == MSRU_ST_IDLE;

    msru_rsv #(
        .ADDR_W (ADDR_W)
    ) u_rsv (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .set_rsv (take && op_kind == MSRU_OP_LOAD_RSV && !misaligned),
        .clr_rsv (snoop_kill ||
                  (take && op_kind == MSRU_OP_STORE_COND)),
        .addr    (op_addr),
        .hit     (rsv_hit)
    );

    // Barrier sequencing
    always_comb begin
        next_state = state;
        case (state)
            MSRU_ST_IDLE: begin
                if (take && op_kind == MSRU_OP_SYNC)
                    next_state = MSRU_ST_SYNC_WAIT;
                else if (take && op_kind == MSRU_OP_EIEIO)
                    next_state = MSRU_ST_EIEIO_WAIT;
                else if (take && op_kind == MSRU_OP_ISYNC)
                    next_state = MSRU_ST_ISYNC_WAIT;
            end
            MSRU_ST_SYNC_WAIT:
                if (older_done) next_state = MSRU_ST_SYNC_BUS;
            MSRU_ST_SYNC_BUS:
                if (bus_ack) next_state = MSRU_ST_IDLE;
            MSRU_ST_EIEIO_WAIT:
                if (older_io_done) next_state = MSRU_ST_EIEIO_BUS;
            MSRU_ST_EIEIO_BUS:
                if (bus_ack) next_state = MSRU_ST_IDLE;
            MSRU_ST_ISYNC_WAIT:
                if (older_done) next_state = MSRU_ST_IDLE;
            default:
                next_state = MSRU_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) state <= MSRU_ST_IDLE;
        else        state <= next_state;
    end

    // Stall younger dispatch while sync or isync is outstanding
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            dispatch_stall <= 1'b0;
        else
            dispatch_stall <= next_state == MSRU_ST_SYNC_WAIT ||
                              next_state == MSRU_ST_SYNC_BUS ||
                              next_state == MSRU_ST_ISYNC_WAIT;
    end

    // Younger cache-inhibited or write-through accesses held behind eieio
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            io_hold <= 1'b0;
        else
            io_hold <= next_state == MSRU_ST_EIEIO_WAIT ||
                       next_state == MSRU_ST_EIEIO_BUS;
    end

    // Bus request: level held until the partner acknowledges
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bus_req <= 1'b0;
            bus_op  <= MSRU_BUS_IDLE;
        end else if (next_state == MSRU_ST_SYNC_BUS) begin
            bus_req <= 1'b1;
            bus_op  <= MSRU_BUS_SYNC;
        end else if (next_state == MSRU_ST_EIEIO_BUS) begin
            bus_req <= 1'b1;
            bus_op  <= MSRU_BUS_EIEIO;
        end else begin
            bus_req <= 1'b0;
            bus_op  <= MSRU_BUS_IDLE;
        end
    end

    // Route memory-sync ops to the load/store unit; misaligned reservation ops trap
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            load_store_unit_issue <= 1'b0;
            load_store_unit_kind  <= MSRU_OP_NONE;
            align_exc             <= 1'b0;
        end else begin
            align_exc <= take && is_rsv_op && misaligned;
            load_store_unit_issue <= take && !(is_rsv_op && misaligned) &&
                                     op_kind != MSRU_OP_ISYNC &&
                                     op_kind != MSRU_OP_NONE;
            load_store_unit_kind  <= take ? op_kind : MSRU_OP_NONE;
        end
    end

    // Store write enable only on a live reservation hit
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            store_we <= 1'b0;
        else
            store_we <= take && op_kind == MSRU_OP_STORE_COND &&
                        !misaligned && rsv_hit;
    end

    // Condition field zero: success or failure code, or undefined for invalid forms or a clear record bit
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cond_we              <= 1'b0;
            condition_field_zero <= MSRU_CR_UNDEF;
        end else begin
            cond_we <= 1'b0;
            if (take && !(is_rsv_op && misaligned)) begin
                if (op_kind == MSRU_OP_STORE_COND) begin
                    cond_we <= 1'b1;
                    if (!op_record_bit)
                        condition_field_zero <= MSRU_CR_UNDEF;
                    else if (rsv_hit)
                        condition_field_zero <= MSRU_CR_EQ;
                    else
                        condition_field_zero <= MSRU_CR_FAIL;
                end else if ((op_kind == MSRU_OP_SYNC ||
                              op_kind == MSRU_OP_LOAD_RSV) &&
                             op_record_bit) begin
                    cond_we              <= 1'b1;
                    condition_field_zero <= MSRU_CR_UNDEF;
                end
            end
        end
    end

    // Capture the isync successor address
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            isync_pc <= '0;
        else if (take && op_kind == MSRU_OP_ISYNC)
            isync_pc <= op_next_pc;
    end

    // Purge and refetch only on isync; sync never purges the buffer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            purge_prefetch <= 1'b0;
            fetch_req      <= 1'b0;
            fetch_addr     <= '0;
        end else begin
            purge_prefetch <= state == MSRU_ST_ISYNC_WAIT &&
                              older_done;
            fetch_req      <= state == MSRU_ST_ISYNC_WAIT && older_done;
            if (state == MSRU_ST_ISYNC_WAIT && older_done)
                fetch_addr <= {isync_pc[ADDR_W-1:MSRU_DWORD_BITS],
                               {MSRU_DWORD_BITS{1'b0}}};
        end
    end

    sequence sync_taken_s;
        take && op_kind == MSRU_OP_SYNC;
    endsequence

    sequence stall_held_s;
        dispatch_stall [*2];
    endsequence

    property sync_stall_p;
        @(posedge clk_sys) disable iff (!rst_b)
        sync_taken_s |=> stall_held_s;
    endproperty

    sync_stall_a: assert property (sync_stall_p)
        else $error("sync did not stall dispatch");

    align_trap_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        take && is_rsv_op && misaligned |=> align_exc && !store_we)
        else $error("misaligned reservation op not trapped");

    sync_no_purge_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        state == MSRU_ST_SYNC_BUS && bus_ack |=> !purge_prefetch)
        else $error("sync purged the instruction buffer");

    sync_bus_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        state == MSRU_ST_SYNC_WAIT && older_done |=>
        bus_req && bus_op == MSRU_BUS_SYNC)
        else $error("sync bus operation missing");

    rec_invalid_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        take && op_kind == MSRU_OP_LOAD_RSV && op_record_bit && !misaligned
        |=> cond_we && condition_field_zero == MSRU_CR_UNDEF)
        else $error("invalid form did not mark condition field");

    stc_norec_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        take && op_kind == MSRU_OP_STORE_COND && !op_record_bit &&
        !misaligned |=> condition_field_zero == MSRU_CR_UNDEF)
        else $error("store-conditional without record bit mishandled");

    eieio_hold_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        state == MSRU_ST_EIEIO_WAIT && !older_io_done |=> io_hold && !bus_req)
        else $error("eieio ran ahead of older accesses");

    eieio_bus_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        state == MSRU_ST_EIEIO_WAIT && older_io_done |=>
        bus_req && bus_op == MSRU_BUS_EIEIO)
        else $error("eieio broadcast missing");

    isync_fetch_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        state == MSRU_ST_ISYNC_WAIT && older_done |=>
        purge_prefetch && fetch_req &&
        fetch_addr[MSRU_DWORD_BITS-1:0] == '0)
        else $error("isync did not purge and refetch");

    stc_success_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        store_we |-> $past(rsv_hit) && condition_field_zero == MSRU_CR_EQ
                     || !$past(op_record_bit))
        else $error("store write without reservation");

    sequence sync_rec_s;
        take && op_kind == MSRU_OP_SYNC && op_record_bit;
    endsequence

    // Invalid record form on sync still marks the field as undefined
    sync_rec_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        sync_rec_s |=> cond_we && condition_field_zero == MSRU_CR_UNDEF)
        else $error("sync record form did not mark condition field");

    sequence bus_done_s;
        (state == MSRU_ST_SYNC_BUS || state == MSRU_ST_EIEIO_BUS) && bus_ack;
    endsequence

    // Acknowledge must release the request, the held dispatch and the I/O hold
    bar_release_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        bus_done_s |=> !bus_req && !dispatch_stall && !io_hold)
        else $error("barrier not released after acknowledge");

    // A trapped reservation op must reach neither the unit nor the field
    align_quiet_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        take && is_rsv_op && misaligned |=>
        !load_store_unit_issue && !cond_we)
        else $error("misaligned reservation op was issued");
endmodule

// [msru_bus_model.sv]
// System bus partner: second-level cache that acknowledges barrier operations
`timescale 1ns/10ps
module msru_bus_model
    import msru_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         bus_req,
    input  wire msru_bus_type bus_op,
    input  wire logic [3:0]   ack_delay,
    output logic              bus_ack,
    output int                n_sync,
    output int                n_order
);
    logic [3:0] wait_cnt;

    // Ack only after queued references drained; the delay stands for that
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bus_ack  <= 1'b0;
            wait_cnt <= 4'h0;
            n_sync   <= 0;
            n_order  <= 0;
        end else if (bus_req && !bus_ack) begin
            if (wait_cnt == ack_delay) begin
                bus_ack  <= 1'b1;
                wait_cnt <= 4'h0;
                if (bus_op == MSRU_BUS_SYNC) n_sync <= n_sync + 1;
                if (bus_op == MSRU_BUS_EIEIO) n_order <= n_order + 1;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end else begin
            bus_ack <= 1'b0; // Single-cycle ack, low once released
        end
    end
endmodule

// [memory_sync_reservation_unit_bench.sv]
// Self-checking bench for the memory sync and reservation unit
`timescale 1ns/10ps
module memory_sync_reservation_unit_bench;
    import msru_pkg::*;
    logic clk_sys, rst_b, op_valid, op_record_bit, older_done, older_io_done;
    logic snoop_kill, bus_ack, dispatch_stall, io_hold, align_exc;
    logic load_store_unit_issue;
    logic bus_req, cond_we, store_we, purge_prefetch, fetch_req;
    msru_op_type  op_kind, load_store_unit_kind;
    msru_bus_type bus_op;
    logic [63:0]  op_addr, op_next_pc, fetch_addr;
    logic [3:0]   condition_field_zero, ack_delay;
    int n_mismatch, n_checks, n_sync, n_order, cycles, i;

    msru_core DUT (.clk_sys(clk_sys), .rst_b(rst_b), .op_valid(op_valid),
        .op_kind(op_kind), .op_record_bit(op_record_bit), .op_addr(op_addr),
        .op_next_pc(op_next_pc), .older_done(older_done),
        .older_io_done(older_io_done), .bus_ack(bus_ack),
        .snoop_kill(snoop_kill), .dispatch_stall(dispatch_stall),
        .io_hold(io_hold), .align_exc(align_exc),
        .load_store_unit_issue(load_store_unit_issue),
        .load_store_unit_kind(load_store_unit_kind),
        .bus_op(bus_op), .bus_req(bus_req),
        .cond_we(cond_we), .condition_field_zero(condition_field_zero),
        .store_we(store_we), .purge_prefetch(purge_prefetch),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr));
    msru_bus_model partner (.clk_sys(clk_sys), .rst_b(rst_b),
        .bus_req(bus_req), .bus_op(bus_op), .ack_delay(ack_delay),
        .bus_ack(bus_ack), .n_sync(n_sync), .n_order(n_order));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Offer one op; returns in the cycle after the edge that takes it
    task automatic offer(input msru_op_type k, input logic r,
                         input logic [63:0] a);
        op_valid      = 1'b1;
        op_kind       = k;
        op_record_bit = r;
        op_addr       = a;
        @(posedge clk_sys); #1;
    endtask

    task automatic step();
        @(posedge clk_sys); #1;
    endtask

    // A held younger op must not be taken and no bus request may start
    task automatic stay_quiet(input int n);
        repeat (n) begin
            step();
            check(load_store_unit_issue, 0);
            check(bus_req, 0);
        end
    endtask

    // Held op goes through once the barrier is finished
    task automatic see_taken(input msru_op_type k);
        for (i = 0; i < 4 && load_store_unit_issue !== 1'b1; i++) step();
        check(load_store_unit_kind, k);
        op_valid = 1'b0;
    endtask

    task automatic t_align();
        offer(MSRU_OP_STORE_COND, 1'b1, 64'h3000); // Drop any reservation
        offer(MSRU_OP_LOAD_RSV, 1'b0, 64'h3002);
        check(align_exc, 1);
        check(load_store_unit_issue, 0);
        offer(MSRU_OP_STORE_COND, 1'b1, 64'h3001);
        check(align_exc, 1);
        check(cond_we, 0);
        check(store_we, 0);
        offer(MSRU_OP_LOAD_RSV, 1'b0, 64'h3004); // Word but not dword aligned
        check(align_exc, 0);
        offer(MSRU_OP_STORE_COND, 1'b1, 64'h3008);
        check(store_we, 1);
        op_valid = 1'b0;
        $display("test align done");
    endtask

    task automatic t_reserve();
        offer(MSRU_OP_LOAD_RSV, 1'b0, 64'h1000);
        offer(MSRU_OP_STORE_COND, 1'b1, 64'h103c); // Last word of block
        check(store_we, 1);
        check(cond_we, 1);
        check(condition_field_zero, MSRU_CR_EQ);
        offer(MSRU_OP_STORE_COND, 1'b1, 64'h1000); // Reservation used up
        check(store_we, 0);
        check(condition_field_zero, MSRU_CR_FAIL);
        offer(MSRU_OP_LOAD_RSV, 1'b0, 64'h1000);
        offer(MSRU_OP_STORE_COND, 1'b1, 64'h1040); // Next block over
        check(store_we, 0);
        offer(MSRU_OP_LOAD_RSV, 1'b0, 64'h1000);
        op_valid   = 1'b0;
        snoop_kill = 1'b1;
        step();
        snoop_kill = 1'b0;
        offer(MSRU_OP_STORE_COND, 1'b1, 64'h1000);
        check(store_we, 0);
        offer(MSRU_OP_LOAD_RSV, 1'b0, 64'h1000);
        offer(MSRU_OP_STORE_COND, 1'b0, 64'h1020); // Record bit clear
        check(store_we, 1);
        check(condition_field_zero, MSRU_CR_UNDEF);
        offer(MSRU_OP_LOAD_RSV, 1'b0, 64'h1000);
        offer(MSRU_OP_STORE_COND, 1'b1, 64'h1000);
        offer(MSRU_OP_LOAD_RSV, 1'b1, 64'h1000); // Invalid record form
        check(cond_we, 1);
        op_valid = 1'b0;
        step();
        check(condition_field_zero, MSRU_CR_UNDEF);
        $display("test reserve done");
    endtask

    task automatic t_sync();
        older_done = 1'b0;
        ack_delay  = 4'h3; // Slow cache
        offer(MSRU_OP_SYNC, 1'b1, 64'h0); // Invalid record form too
        check(cond_we, 1);
        check(dispatch_stall, 1);
        check(load_store_unit_kind, MSRU_OP_SYNC);
        op_kind = MSRU_OP_LOAD_RSV; // Younger op held by dispatch
        op_addr = 64'h2000;
        stay_quiet(3);
        older_done = 1'b1;
        step();
        check(bus_req, 1);
        check(bus_op, MSRU_BUS_SYNC);
        for (i = 0; i < 10 && dispatch_stall === 1'b1; i++) begin
            check(load_store_unit_issue, 0);
            check(purge_prefetch, 0);
            step();
        end
        check(dispatch_stall, 0);
        check(n_sync, 1);
        see_taken(MSRU_OP_LOAD_RSV);
        $display("test sync done");
    endtask

    task automatic t_order();
        older_io_done = 1'b0;
        ack_delay     = 4'h0; // Prompt cache
        offer(MSRU_OP_EIEIO, 1'b0, 64'h0);
        check(io_hold, 1);
        check(load_store_unit_kind, MSRU_OP_EIEIO);
        op_kind = MSRU_OP_MEM_CI; // Younger I/O access held
        stay_quiet(3);
        older_io_done = 1'b1;
        step();
        check(bus_req, 1);
        check(bus_op, MSRU_BUS_EIEIO);
        for (i = 0; i < 10 && io_hold === 1'b1; i++) step();
        check(n_order, 1);
        see_taken(MSRU_OP_MEM_CI);
        $display("test order done");
    endtask

    task automatic t_isync();
        older_done = 1'b0;
        op_next_pc = 64'h0000_0000_0000_4008;
        offer(MSRU_OP_ISYNC, 1'b0, 64'h0);
        op_valid = 1'b0;
        check(dispatch_stall, 1);
        repeat (2) begin
            step();
            check(purge_prefetch, 0);
            check(fetch_req, 0);
        end
        older_done = 1'b1;
        step();
        check(purge_prefetch, 1);
        check(fetch_req, 1);
        check(fetch_addr, 64'h0000_0000_0000_4008);
        step();
        check(purge_prefetch, 0);
        $display("test isync done");
    endtask

    // Guard against a hung handshake
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        {rst_b, op_valid, op_record_bit, snoop_kill} = 4'h0;
        {older_done, older_io_done} = 2'b11;
        op_kind    = MSRU_OP_NONE;
        op_addr    = 64'h0;
        op_next_pc = 64'h0;
        ack_delay  = 4'h0;
        n_mismatch = 0;
        n_checks   = 0;
        cycles     = 0;
        repeat (6) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        check(dispatch_stall, 0);
        check(bus_req, 0);
        t_align();
        t_reserve();
        t_sync();
        t_order();
        t_isync();
        give_verdict();
    end
endmodule
